// file: design/cbx_alu.sv
// combinational datapath for the covered instruction group
`include "cbx_cfg.svh"
`default_nettype none
module cbx_alu (
  input  wire cbx_pkg::cbx_op_t op,
  input  wire logic [7:0]       opnd,
  input  wire logic [7:0]       working_register,
  input  wire logic [2:0]       bsel,
  input  wire logic [4:0]       flags_in,
  output logic      [7:0]       result,
  output logic      [4:0]       flags_out,
  output logic                  skip
);
  import cbx_pkg::*;
  // shared terms
  logic [7:0] bmask;
  logic       bit_v;
  logic [7:0] dec_v;
  logic [7:0] rot_v;
  logic       lo_adj;
  logic       hi_adj;
  logic [8:0] daw_v;
  assign bmask  = 8'h01 << bsel;
  assign bit_v  = |(opnd & bmask);
  assign dec_v  = opnd - 8'h01;
  assign rot_v  = {opnd[6:0], opnd[7]};
  assign lo_adj = (working_register[3:0] > `CBX_BCD_MAX) | flags_in[`CBX_FLG_DC];
  assign hi_adj = (working_register[7:4] > `CBX_BCD_MAX) | flags_in[`CBX_FLG_C];
  // nibble carry from the low fix-up ripples into the high nibble
  assign daw_v  = {1'b0, working_register} + (lo_adj ? `CBX_BCD_LO_ADJ : 9'h000)
                + (hi_adj ? `CBX_BCD_HI_ADJ : 9'h000);

  // result, flags and skip per operation; flags untouched unless listed
  always_comb begin
    result    = opnd;
    flags_out = flags_in;
    skip      = 1'b0;
    case (op)
      CBX_DECIMAL_ADJUST_OP: begin
        result = daw_v[7:0];
        flags_out[`CBX_FLG_C] = daw_v[8] | flags_in[`CBX_FLG_C];
      end
      CBX_DECREMENT_OP: begin
        result = dec_v;
        flags_out[`CBX_FLG_C]  = (opnd != 8'h00);
        flags_out[`CBX_FLG_DC] = (opnd[3:0] != 4'h0);
        flags_out[`CBX_FLG_Z]  = (dec_v == 8'h00);
        flags_out[`CBX_FLG_OV] = (opnd == 8'h80);
        flags_out[`CBX_FLG_N]  = dec_v[7];
      end
      CBX_ROTATE_LEFT_NOCARRY_OP: begin
        result = rot_v;
        flags_out[`CBX_FLG_Z] = (rot_v == 8'h00);
        flags_out[`CBX_FLG_N] = rot_v[7];
      end
      CBX_COMPARE_SKIP_GREATER_OP: skip = (opnd > working_register);
      CBX_COMPARE_SKIP_LESS_OP:    skip = (opnd < working_register);
      CBX_BIT_CLEAR_OP:            result = opnd & ~bmask;
      CBX_BIT_SET_OP:              result = opnd | bmask;
      CBX_BIT_TOGGLE_OP:           result = opnd ^ bmask;
      CBX_BIT_TEST_SKIP_CLEAR_OP:  skip = ~bit_v;
      CBX_BIT_TEST_SKIP_SET_OP:    skip = bit_v;
      default:                     skip = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: design/cbx_bank.sv
// data address former from access bit, file byte and bank select
`include "cbx_cfg.svh"
`default_nettype none
module cbx_bank (
  input  wire logic        acc_sel,
  input  wire logic [7:0]  fbyte,
  input  wire logic [3:0]  bank_select_register,
  output logic      [11:0] daddr
);
  import cbx_pkg::*;
  // access bank: low half in bank 0, upper half in the special bank
  logic [3:0] acc_bank;
  assign acc_bank = (fbyte < `CBX_ACC_SPLIT) ? `CBX_ACC_LOBANK : `CBX_ACC_HIBANK;
  assign daddr    = {acc_sel ? bank_select_register : acc_bank, fbyte};
endmodule
`default_nettype wire

// file: design/cbx_cfg.svh
// constants for the bit-op / compare-skip execution core
`ifndef CBX_CFG_SVH
`define CBX_CFG_SVH

// register byte offsets
`define CBX_ADDR_CTRL   12'h000
`define CBX_ADDR_WORKING_REGISTER   12'h004
`define CBX_ADDR_STAT   12'h008
`define CBX_ADDR_BSR    12'h00c
`define CBX_ADDR_EXEC   12'h010
`define CBX_ADDR_CFG    12'h014
`define CBX_ADDR_PORT   12'h018
`define CBX_MEM_SEL     2'h1
// ctrl fields
`define CBX_CTRL_NXT2   16
`define CBX_CTRL_ALONE  17
// status flag positions
`define CBX_FLG_C       0
`define CBX_FLG_DC      1
`define CBX_FLG_Z       2
`define CBX_FLG_OV      3
`define CBX_FLG_N       4
// reset values
`define CBX_RST_WORKING_REGISTER    8'h00
`define CBX_RST_FLAGS   5'h00
`define CBX_RST_BSR     4'h0
`define CBX_RST_IR      16'h0000
// opcode patterns
`define CBX_PAT_DAW     16'h0007
`define CBX_PAT_DEC     6'h01
`define CBX_PAT_RLN     6'h11
`define CBX_PAT_CGT     7'h32
`define CBX_PAT_CLT     7'h30
`define CBX_PAT_BCF     4'h9
`define CBX_PAT_BSF     4'h8
`define CBX_PAT_BTG     4'h7
`define CBX_PAT_BTSC    4'hb
`define CBX_PAT_BTSS    4'ha
// bank forming and decimal adjust
`define CBX_ACC_SPLIT   8'h80
`define CBX_ACC_LOBANK  4'h0
`define CBX_ACC_HIBANK  4'hf
`define CBX_BCD_MAX     4'h9
`define CBX_BCD_LO_ADJ  9'h006
`define CBX_BCD_HI_ADJ  9'h060
`endif

// file: design/cbx_core.sv
// execution core for bit ops, compare-skip, decimal adjust, decrement, rotate
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "cbx_cfg.svh"
`default_nettype none
module cbx_core #(
  parameter int          DM_DEPTH  = 256,
  parameter logic [11:0] PORT_ADDR = 12'hf80,
  parameter logic [11:0] T0_ADDR   = 12'hf81
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_pins,
  input  wire logic        tbl_wr_start,
  input  wire logic        tbl_wr_done,
  output logic      [7:0]  port_latch,
  output logic             t0_presc_clr,
  output logic             tbl_wr_active,
  output logic             core_busy
);
  import cbx_pkg::*;
  localparam int DM_AW = $clog2(DM_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [7:0]  pin_m_r, pin_s_r;
  logic [1:0]  tws_m_r, tws_s_r;
  logic [15:0] ir_r;
  logic        nxt2_r, alone_r;
  logic [7:0]  working_register_r;
  logic [4:0]  flags_r;
  logic [3:0]  bank_select_register_r;
  logic        presc_en_r;
  logic [7:0]  port_latch_r;
  logic        t0_clr_r;
  logic        tbl_act_r;
  cbx_q_t      q_r, q_nxt;
  logic        nop_cyc_r;
  logic [1:0]  extra_r;
  logic [1:0]  cyc_r;
  cbx_op_t     op_r;
  logic [11:0] addr_r;
  logic        d_r;
  logic [2:0]  bsel_r;
  logic [7:0]  opnd_r, res_r;
  logic [4:0]  flg_r;
  logic        skip_r;
  logic [7:0]  dmem_r [DM_DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; two-cycle access phase so read data leaves a flop
  logic acc_go, done, wr_ok, aligned, busy;
  logic hit_ctrl, hit_w, hit_st, hit_bsr, hit_ex, hit_cfg, hit_port, hit_mem, hit;
  logic err;
  logic [DM_AW-1:0] m_idx;
  logic [31:0] rd_data;
  assign acc_go   = psel & penable & ~pready_r;
  assign done     = psel & penable & pready_r;
  assign wr_ok    = done & pwrite & ~pslverr_r;
  assign busy     = (q_r != Q_IDLE);
  assign aligned  = (paddr[1:0] == 2'b00);
  assign hit_ctrl = (paddr == `CBX_ADDR_CTRL);
  assign hit_w    = (paddr == `CBX_ADDR_WORKING_REGISTER);
  assign hit_st   = (paddr == `CBX_ADDR_STAT);
  assign hit_bsr  = (paddr == `CBX_ADDR_BSR);
  assign hit_ex   = (paddr == `CBX_ADDR_EXEC);
  assign hit_cfg  = (paddr == `CBX_ADDR_CFG);
  assign hit_port = (paddr == `CBX_ADDR_PORT);
  assign hit_mem  = (paddr[11:10] == `CBX_MEM_SEL) & aligned;
  assign hit      = hit_ctrl | hit_w | hit_st | hit_bsr | hit_ex | hit_cfg | hit_port | hit_mem;
  assign m_idx    = paddr[2 +: DM_AW];
  // writes other than config are refused while an instruction runs
  assign err      = ~hit | (pwrite & (hit_ex | hit_port | (busy & ~hit_cfg)));
  assign rd_data  = hit_ctrl ? {14'h0000, alone_r, nxt2_r, ir_r}
                  : hit_w    ? {24'h000000, working_register_r}
                  : hit_st   ? {27'h0000000, flags_r}
                  : hit_bsr  ? {28'h0000000, bank_select_register_r}
                  : hit_ex   ? {26'h0000000, tbl_act_r, cyc_r, nop_cyc_r, skip_r, busy}
                  : hit_cfg  ? {31'h00000000, presc_en_r}
                  : hit_port ? {16'h0000, port_latch_r, pin_s_r}
                  : hit_mem  ? {24'h000000, dmem_r[m_idx]}
                  : 32'h00000000;

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r <= acc_go;
      if (acc_go) begin
        pslverr_r <= err;
        prdata_r  <= pwrite ? 32'h00000000 : rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_m_r <= 8'h00;
      pin_s_r <= 8'h00;
      tws_m_r <= 2'b00;
      tws_s_r <= 2'b00;
    end else begin
      pin_m_r <= port_pins;
      pin_s_r <= pin_m_r;
      tws_m_r <= {tbl_wr_done, tbl_wr_start};
      tws_s_r <= tws_m_r;
    end
  end

  // table write runs until its own end; start wins over a same-cycle end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tbl_act_r <= 1'b0;
    else if (tws_s_r[0])
      tbl_act_r <= 1'b1;
    else if (tws_s_r[1])
      tbl_act_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of the held word
  logic    launch, q_end, more, in_exec;
  cbx_op_t dec_op;
  logic [11:0] bank_addr;
  assign launch  = wr_ok & hit_ctrl;
  assign q_end   = (q_r == Q_WRITE);
  assign in_exec = ~nop_cyc_r;
  // a second word seen alone decodes as no operation
  assign dec_op = alone_r ? CBX_NOP
    : (ir_r == `CBX_PAT_DAW)        ? CBX_DECIMAL_ADJUST_OP
    : (ir_r[15:10] == `CBX_PAT_DEC) ? CBX_DECREMENT_OP
    : (ir_r[15:10] == `CBX_PAT_RLN) ? CBX_ROTATE_LEFT_NOCARRY_OP
    : (ir_r[15:9] == `CBX_PAT_CGT)  ? CBX_COMPARE_SKIP_GREATER_OP
    : (ir_r[15:9] == `CBX_PAT_CLT)  ? CBX_COMPARE_SKIP_LESS_OP
    : (ir_r[15:12] == `CBX_PAT_BCF) ? CBX_BIT_CLEAR_OP
    : (ir_r[15:12] == `CBX_PAT_BSF) ? CBX_BIT_SET_OP
    : (ir_r[15:12] == `CBX_PAT_BTG) ? CBX_BIT_TOGGLE_OP
    : (ir_r[15:12] == `CBX_PAT_BTSC) ? CBX_BIT_TEST_SKIP_CLEAR_OP
    : (ir_r[15:12] == `CBX_PAT_BTSS) ? CBX_BIT_TEST_SKIP_SET_OP
    : CBX_NOP;

  cbx_bank u_bank (
    .acc_sel              (ir_r[8]),
    .fbyte                (ir_r[7:0]),
    .bank_select_register (bank_select_register_r),
    .daddr                (bank_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // quarter-phase sequencer; skipped cycles replay all four quarters idle
  assign more = nop_cyc_r ? (extra_r != 2'd1) : skip_r;
  always_comb begin
    case (q_r)
      Q_IDLE:   q_nxt = launch ? Q_DECODE : Q_IDLE;
      Q_DECODE: q_nxt = Q_READ;
      Q_READ:   q_nxt = Q_PROC;
      Q_PROC:   q_nxt = Q_WRITE;
      Q_WRITE:  q_nxt = more ? Q_DECODE : Q_IDLE;
      default:  q_nxt = Q_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r       <= Q_IDLE;
      nop_cyc_r <= 1'b0;
      extra_r   <= 2'd0;
      cyc_r     <= 2'd0;
    end else begin
      q_r <= q_nxt;
      if (launch) begin
        nop_cyc_r <= 1'b0;
        cyc_r     <= 2'd0;
      end else if (q_end) begin
        cyc_r <= cyc_r + 2'd1;
        if (in_exec && skip_r) begin
          nop_cyc_r <= 1'b1;
          extra_r   <= nxt2_r ? 2'd2 : 2'd1;
        end else if (nop_cyc_r) begin
          extra_r <= extra_r - 2'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath per quarter: latch fields, read operand, process
  logic [7:0] alu_res;
  logic [4:0] alu_flg;
  logic       alu_skip;
  logic [7:0] rd_opnd;
  // port as source reads the pins, so read-modify-write sees pin levels
  assign rd_opnd = (op_r == CBX_DECIMAL_ADJUST_OP) ? working_register_r
                 : (addr_r == PORT_ADDR) ? pin_s_r
                 : dmem_r[addr_r[DM_AW-1:0]];

  cbx_alu u_alu (
    .op               (op_r),
    .opnd             (opnd_r),
    .working_register (working_register_r),
    .bsel             (bsel_r),
    .flags_in         (flags_r),
    .result           (alu_res),
    .flags_out        (alu_flg),
    .skip             (alu_skip)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r   <= CBX_NOP;
      addr_r <= 12'h000;
      d_r    <= 1'b0;
      bsel_r <= 3'd0;
      opnd_r <= 8'h00;
      res_r  <= 8'h00;
      flg_r  <= `CBX_RST_FLAGS;
      skip_r <= 1'b0;
    end else if (in_exec) begin
      if (q_r == Q_DECODE) begin
        op_r   <= dec_op;
        addr_r <= bank_addr;
        d_r    <= ir_r[9];
        bsel_r <= ir_r[11:9];
      end
      if (q_r == Q_READ)
        opnd_r <= rd_opnd;
      if (q_r == Q_PROC) begin
        res_r  <= alu_res;
        flg_r  <= alu_flg;
        skip_r <= alu_skip;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fourth quarter: destination write; compares write nothing
  logic dst_op, bit_op, wr_w, wr_f;
  assign dst_op = (op_r == CBX_DECREMENT_OP) | (op_r == CBX_ROTATE_LEFT_NOCARRY_OP);
  assign bit_op = (op_r == CBX_BIT_CLEAR_OP) | (op_r == CBX_BIT_SET_OP) | (op_r == CBX_BIT_TOGGLE_OP);
  assign wr_w   = q_end & in_exec & ((op_r == CBX_DECIMAL_ADJUST_OP) | (dst_op & ~d_r));
  assign wr_f   = q_end & in_exec & ((dst_op & d_r) | bit_op);

  // architectural registers; bus writes other than config only land while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_r                   <= `CBX_RST_IR;
      nxt2_r                 <= 1'b0;
      alone_r                <= 1'b0;
      working_register_r     <= `CBX_RST_WORKING_REGISTER;
      flags_r                <= `CBX_RST_FLAGS;
      bank_select_register_r <= `CBX_RST_BSR;
      presc_en_r             <= 1'b0;
      port_latch_r           <= 8'h00;
      t0_clr_r               <= 1'b0;
    end else begin
      if (launch) begin
        ir_r    <= pwdata[15:0];
        nxt2_r  <= pwdata[`CBX_CTRL_NXT2];
        alone_r <= pwdata[`CBX_CTRL_ALONE];
      end
      if (wr_ok & hit_w)
        working_register_r <= pwdata[7:0];
      else if (wr_w)
        working_register_r <= res_r;
      if (wr_ok & hit_st)
        flags_r <= pwdata[4:0];
      else if (q_end & in_exec)
        flags_r <= flg_r;
      if (wr_ok & hit_bsr)
        bank_select_register_r <= pwdata[3:0];
      if (wr_ok & hit_cfg)
        presc_en_r <= pwdata[0];
      if (wr_f && addr_r == PORT_ADDR)
        port_latch_r <= res_r;
      t0_clr_r <= wr_f & (addr_r == T0_ADDR) & presc_en_r;
    end
  end

  // data memory has no reset; it is plain storage
  always_ff @(posedge pclk) begin
    if (wr_ok & hit_mem)
      dmem_r[m_idx] <= pwdata[7:0];
    else if (wr_f && addr_r != PORT_ADDR)
      dmem_r[addr_r[DM_AW-1:0]] <= res_r;
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign port_latch    = port_latch_r;
  assign t0_presc_clr  = t0_clr_r;
  assign tbl_wr_active = tbl_act_r;
  assign core_busy     = (q_r != Q_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_skip_clear_test: assert property ((q_r == Q_PROC) && in_exec && op_r == CBX_BIT_TEST_SKIP_CLEAR_OP
    |=> skip_r == ~opnd_r[bsel_r]) else $error("bit test clear skip wrong");
  a_skip_one_word: assert property (q_end && in_exec && skip_r && !nxt2_r
    |=> (q_r != Q_IDLE)[*4] ##1 (q_r == Q_IDLE)) else $error("one-word skip not two cycles");
  a_skip_two_word: assert property (q_end && in_exec && skip_r && nxt2_r
    |=> (q_r != Q_IDLE)[*8] ##1 (q_r == Q_IDLE)) else $error("two-word skip not three cycles");
  a_port_pin_src: assert property ((q_r == Q_READ) && in_exec && addr_r == PORT_ADDR
    && op_r != CBX_DECIMAL_ADJUST_OP |=> opnd_r == $past(pin_s_r)) else $error("port source not pins");
  a_presc_clear: assert property (wr_f && addr_r == T0_ADDR && presc_en_r
    |=> t0_presc_clr) else $error("prescaler not cleared");
  a_nop_cycle_quiet: assert property (nop_cyc_r && (q_r == Q_DECODE)
    |=> $stable(working_register_r) [*3] ##1 $stable(flags_r)) else $error("skip cycle changed state");
  a_cmp_greater: assert property ((q_r == Q_PROC) && in_exec && op_r == CBX_COMPARE_SKIP_GREATER_OP
    |=> skip_r == ($past(opnd_r) > working_register_r) && flags_r == $past(flags_r)) else $error("greater compare");
  a_cmp_less: assert property ((q_r == Q_PROC) && in_exec && op_r == CBX_COMPARE_SKIP_LESS_OP
    |=> skip_r == ($past(opnd_r) < working_register_r)) else $error("less compare");
  a_dest_working_register: assert property (q_end && in_exec && op_r == CBX_DECREMENT_OP && !d_r
    |=> working_register_r == $past(res_r)) else $error("decrement not to working register");
  a_table_hold: assert property (tbl_act_r && !tws_s_r[1] |=> tbl_act_r)
    else $error("table write dropped early");

  c_skip_one: cover property (q_end && in_exec && skip_r && !nxt2_r);
  c_skip_two: cover property (q_end && in_exec && skip_r && nxt2_r);
  c_daw_run: cover property (wr_w && op_r == CBX_DECIMAL_ADJUST_OP);
  c_presc: cover property (t0_presc_clr);
endmodule
`default_nettype wire

// file: design/cbx_pkg.sv
// types shared by the execution core
`default_nettype none
package cbx_pkg;
  typedef enum logic [3:0] {
    CBX_NOP, CBX_DECIMAL_ADJUST_OP, CBX_DECREMENT_OP, CBX_ROTATE_LEFT_NOCARRY_OP,
    CBX_COMPARE_SKIP_GREATER_OP, CBX_COMPARE_SKIP_LESS_OP, CBX_BIT_CLEAR_OP,
    CBX_BIT_SET_OP, CBX_BIT_TOGGLE_OP, CBX_BIT_TEST_SKIP_CLEAR_OP, CBX_BIT_TEST_SKIP_SET_OP
  } cbx_op_t;
  typedef enum {Q_IDLE, Q_DECODE, Q_READ, Q_PROC, Q_WRITE} cbx_q_t;
endpackage
`default_nettype wire

// file: sim/cbx_core_tb.sv
// self-checking bench for the execution core
`default_nettype none
module cbx_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tbl_go = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, tbl_wr_start, tbl_wr_done, t0_presc_clr, tbl_wr_active, core_busy, errv;
  logic [7:0]  port_pins, port_latch, presc_clears, port_drive = 8'h3c;
  int          failures = 0, samples_checked = 0;
  always #50 pclk = ~pclk;
  cbx_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pins(port_pins), .tbl_wr_start(tbl_wr_start), .tbl_wr_done(tbl_wr_done),
    .port_latch(port_latch), .t0_presc_clr(t0_presc_clr), .tbl_wr_active(tbl_wr_active),
    .core_busy(core_busy));
  cbx_far_model far (.pclk(pclk), .presetn(presetn), .port_drive(port_drive), .tbl_go(tbl_go),
    .tbl_wr_active(tbl_wr_active), .t0_presc_clr(t0_presc_clr), .port_pins(port_pins),
    .tbl_wr_start(tbl_wr_start), .tbl_wr_done(tbl_wr_done), .presc_clears(presc_clears));
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // one apb transfer; a spare edge after release keeps back-to-back calls glitch free
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      check(1'b0, "apb timeout");
      conclude();
    end
    @(posedge pclk);
  endtask
  function automatic logic [11:0] mem(input logic [7:0] i);
    return 12'h400 + {2'b00, i, 2'b00};
  endfunction
  task automatic chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    check((rdv[7:0] & m) === e, "read value");
  endtask
  // launch one instruction and time it by core_busy and the cycle field
  task automatic run(input logic [17:0] c, input int ncyc);
    int n;
    n = 0;
    apb(1'b1, 12'h000, {14'h0, c});
    while (core_busy === 1'b1 && n < 60) begin
      n++;
      @(posedge pclk);
    end
    check(n == 4 * ncyc, "busy length");
    if (n >= 60) begin
      conclude();
    end
    apb(1'b0, 12'h010, 32'h0);
    check(rdv[4:3] === ncyc[1:0], "cycles taken");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_dec();
    apb(1'b1, mem(8'h10), 32'h1);
    apb(1'b1, 12'h008, 32'h0);
    run(18'h00610, 1);
    chk(mem(8'h10), 8'hff, 8'h00);
    chk(12'h008, 8'h04, 8'h04);
    run(18'h00410, 1);
    chk(12'h004, 8'hff, 8'hff);
    chk(mem(8'h10), 8'hff, 8'h00);
    apb(1'b1, mem(8'h10), 32'h80);
    run(18'h00610, 1);
    chk(12'h008, 8'h1c, 8'h08);
    run(18'h20610, 1);
    chk(mem(8'h10), 8'hff, 8'h7f);
  endtask
  task automatic t_rot_daw();
    logic [7:0] din [2] = '{8'ha5, 8'hce};
    logic [7:0] dout [2] = '{8'h05, 8'h34};
    apb(1'b1, mem(8'h11), 32'hab);
    apb(1'b1, 12'h008, 32'h1);
    run(18'h04611, 1);
    chk(mem(8'h11), 8'hff, 8'h57);
    chk(12'h008, 8'h15, 8'h01);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 12'h004, {24'h0, din[i]});
      apb(1'b1, 12'h008, 32'h0);
      run(18'h00007, 1);
      chk(12'h004, 8'hff, dout[i]);
      chk(12'h008, 8'h1f, 8'h01);
    end
  endtask
  task automatic t_bits();
    logic [17:0] op [3] = '{18'h09812, 18'h08612, 18'h07e12};
    logic [7:0]  ex [3] = '{8'he0, 8'he8, 8'h68};
    apb(1'b1, mem(8'h12), 32'hf0);
    apb(1'b1, 12'h008, 32'h1f);
    for (int i = 0; i < 3; i++) begin
      run(op[i], 1);
      chk(mem(8'h12), 8'hff, ex[i]);
    end
    chk(12'h008, 8'h1f, 8'h1f);
  endtask
  // bit tests over 0x68, then compares of 0x50 against the working register
  task automatic t_skip();
    logic [17:0] op [10] = '{18'h0b612, 18'h0b812, 18'h1b812, 18'h0a612, 18'h0a812,
                             18'h06413, 18'h16413, 18'h06413, 18'h06013, 18'h06013};
    logic [7:0]  w [10] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h40, 8'h40, 8'h50, 8'h50, 8'h51};
    int          nc [10] = '{1, 2, 3, 2, 1, 2, 3, 1, 1, 2};
    apb(1'b1, mem(8'h13), 32'h50);
    apb(1'b1, 12'h008, 32'h0a);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, 12'h004, {24'h0, w[i]});
      run(op[i], nc[i]);
    end
    chk(12'h008, 8'h1f, 8'h0a);
  endtask
  task automatic t_port();
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, mem(8'h80), 32'h21);
    run(18'h00580, 1);
    chk(12'h004, 8'hff, 8'h20);
    run(18'h00480, 1);
    chk(12'h004, 8'hff, 8'h3b);
    apb(1'b1, 12'h00c, 32'hf);
    run(18'h00580, 1);
    chk(12'h004, 8'hff, 8'h3b);
    run(18'h08e80, 1);
    check(port_latch === 8'hbc, "port latch");
  endtask
  task automatic t_t0();
    logic [7:0] k;
    k = presc_clears;
    // timer byte is plain memory with no reset, so give it a known value first
    apb(1'b1, mem(8'h81), 32'h5);
    apb(1'b1, 12'h014, 32'h1);
    run(18'h00681, 1);
    run(18'h00481, 1);
    apb(1'b1, 12'h014, 32'h0);
    run(18'h00681, 1);
    check(presc_clears === k + 8'h01, "prescaler clears");
  endtask
  // a started table write must stay active until the memory ends it
  task automatic t_tbl();
    int n;
    n = 0;
    tbl_go <= 1'b1;
    @(posedge pclk);
    tbl_go <= 1'b0;
    repeat (8) @(posedge pclk);
    check(tbl_wr_active === 1'b1, "table write held");
    while (tbl_wr_active !== 1'b0 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    check(n < 40 && n > 0, "table write end");
    if (n >= 40) begin
      conclude();
    end
  endtask
  task automatic t_err();
    apb(1'b1, 12'h010, 32'h0);
    check(errv === 1'b1, "exec write refused");
    apb(1'b0, 12'h01c, 32'h0);
    check(errv === 1'b1, "unmapped refused");
    apb(1'b1, 12'h000, 32'h7);
    apb(1'b1, 12'h004, 32'h5);
    check(errv === 1'b1, "busy write refused");
    repeat (8) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(pready === 1'b0 && core_busy === 1'b0 && tbl_wr_active === 1'b0, "reset outputs");
    t_dec();
    t_rot_daw();
    t_bits();
    t_skip();
    t_port();
    t_t0();
    t_tbl();
    t_err();
    conclude();
  end
endmodule
`default_nettype wire

// file: sim/cbx_far_model.sv
// far-side model: port pins, timer-zero prescaler and table write memory
`default_nettype none
module cbx_far_model #(
  parameter int DONE_DLY = 10
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] port_drive,
  input  wire logic       tbl_go,
  input  wire logic       tbl_wr_active,
  input  wire logic       t0_presc_clr,
  output logic      [7:0] port_pins,
  output logic            tbl_wr_start,
  output logic            tbl_wr_done,
  output logic      [7:0] presc_clears
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_r;
  // pins follow the outside driver, which is never left floating
  assign port_pins = port_drive;
  // the memory ends a write only after DONE_DLY cycles, so the core must hold it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_wr_start <= 1'b0;
      tbl_wr_done  <= 1'b0;
      cnt_r        <= 0;
      presc_clears <= 8'h00;
    end else begin
      tbl_wr_start <= tbl_go;
      cnt_r        <= tbl_wr_active ? cnt_r + 1 : 0;
      tbl_wr_done  <= tbl_wr_active && cnt_r == DONE_DLY;
      if (t0_presc_clr) begin
        presc_clears <= presc_clears + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire
